/* File: hdl/tgac_counter.sv */
// 16-bit gated counter with asynchronous external count input
//------------------------------------------------------------
// Operation
// RULE1 - no-sync bit counts external edges without aligning to the internal clock
// RULE2 - async external counting keeps running in sleep; overflow wakes processor
// RULE3 - mode switches may drop or add one increment; acceptable
// RULE4 - byte reads during async counting return stable, untorn values
// RULE5 - software stops the counter before writing count bytes
// RULE6 - software allows for overflow between the two byte reads
// RULE7 - gate enable makes counting follow gate; polarity picks active level
// RULE8 - active gate increments on clock rise; inactive holds count
// RULE9 - source field: pin, eight-bit overflow, period match, watchdog overflow
// RULE10 - eight-bit timer roll FF to 00 gives rising pulse to gate
// RULE11 - period timer reset after match gives rising pulse to gate
// RULE12 - watchdog oscillator runs when gate enabled and source is watchdog
// RULE13 - gating watchdog never enables watchdog reset or wake by itself
// RULE14 - prescaler assign and rate bits still choose watchdog interval
// RULE15 - software accounts for watchdog clears and disables other wakes
// RULE16 - software uses toggle mode and setup sequence with watchdog gate
// RULE17 - toggle flip-flop changes on every rising edge of gate source
// RULE18 - toggle bit clear forces and holds flip-flop at zero
// RULE19 - software avoids enabling toggle while changing polarity
// RULE20 - off when on bit 0; always counts without gate; else gated
// RULE21 - toggle flip-flop and gate logic clear on reset
//------------------------------------------------------------
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module tgac_counter
    import tgac_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // register port
    input  wire logic [3:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    // count, gate, watchdog clear and sleep inputs
    input  wire logic       count_clk_in,
    input  wire logic       gate_input,
    input  wire logic [7:0] eight_bit_timer_count,
    input  wire logic [7:0] period_timer_count,
    input  wire logic       watchdog_clear_instr,
    input  wire logic       sleep_active,
    // status outputs
    output logic            overflow_pulse,
    output logic            wake_request,
    output logic            watchdog_osc_on,
    output logic            watchdog_reset_req
);

    //------------------------------------------------------------
    // control registers
    //------------------------------------------------------------
    tgac_bus_t  bus;
    logic       counter_on_bit;
    logic       async_select_bit;
    tgac_gate_t gate_ctl;
    logic       prescaler_assign_bit;
    logic [2:0] prescaler_rate_field;
    logic       watchdog_enable_fuse;

    assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
        return a == target;
    endfunction

    wire wr_ctrl = bus.wr && hit(bus.addr, ADDR_CTRL);
    wire wr_gate = bus.wr && hit(bus.addr, ADDR_GATE);
    wire wr_lo   = bus.wr && hit(bus.addr, ADDR_CNT_LO);
    wire wr_hi   = bus.wr && hit(bus.addr, ADDR_CNT_HI);
    wire wr_wdog = bus.wr && hit(bus.addr, ADDR_WDOG);

    // control register writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            counter_on_bit       <= 1'b0;
            async_select_bit     <= 1'b0;
            gate_ctl             <= '{enable: 1'b0, polarity: 1'b0, toggle: 1'b0, source: TGAC_SRC_PIN}; // [RULE21]
            prescaler_assign_bit <= 1'b0;
            prescaler_rate_field <= 3'h0;
            watchdog_enable_fuse <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                counter_on_bit   <= bus.wdata[CTRL_ON_BIT];
                async_select_bit <= bus.wdata[CTRL_ASYNC_BIT];
            end
            if (wr_gate) begin
                gate_ctl.enable   <= bus.wdata[GATE_EN_BIT];
                gate_ctl.polarity <= bus.wdata[GATE_POL_BIT];
                gate_ctl.toggle   <= bus.wdata[GATE_TGL_BIT];
                gate_ctl.source   <= tgac_src_t'(bus.wdata[GATE_SRC_LSB +: 2]);
            end
            if (wr_wdog) begin
                prescaler_rate_field <= bus.wdata[WD_RATE_LSB +: 3];
                prescaler_assign_bit <= bus.wdata[WD_ASSIGN_BIT];
                watchdog_enable_fuse <= bus.wdata[WD_FUSE_BIT];
            end
        end
    end

    //------------------------------------------------------------
    // internal gate pulse sources
    //------------------------------------------------------------
    logic [7:0] t0_prev;
    logic [7:0] t2_prev;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            t0_prev <= RESET_BYTE;
            t2_prev <= RESET_BYTE;
        end else begin
            t0_prev <= eight_bit_timer_count;
            t2_prev <= period_timer_count;
        end
    end
    wire t0_pulse = (t0_prev == T0_TOP) && (eight_bit_timer_count == RESET_BYTE);        // [RULE10]
    wire t2_pulse = (t2_prev != T2_ZERO) && (period_timer_count == T2_ZERO);             // [RULE11]

    //------------------------------------------------------------
    // watchdog oscillator, prescaler and counter
    //------------------------------------------------------------
    wire wd_gating = gate_ctl.enable && (gate_ctl.source == TGAC_SRC_WDOG);
    assign watchdog_osc_on = watchdog_enable_fuse || wd_gating;                          // [RULE12]
    logic [15:0] wd_count;
    logic [7:0]  wd_pre;
    // prescaler only divides the watchdog when assigned to it
    wire  [7:0]  wd_pre_top = prescaler_assign_bit ? 8'((WD_PRE_ONE << prescaler_rate_field) - 8'h01)
                                                   : RESET_BYTE;                         // [RULE14]
    wire         wd_tick    = (wd_count == WD_BASE_TOP) && (wd_pre == wd_pre_top);
    always_ff @(posedge ref_clk) begin
        if (reset || !watchdog_osc_on || watchdog_clear_instr) begin
            wd_count <= COUNT_ZERO;
            wd_pre   <= RESET_BYTE;
        end else if (wd_count == WD_BASE_TOP) begin
            wd_count <= COUNT_ZERO;
            wd_pre   <= (wd_pre == wd_pre_top) ? RESET_BYTE : 8'(wd_pre + 8'h01);
        end else begin
            wd_count <= 16'(wd_count + COUNT_ONE);
        end
    end
    // only the fuse arms the watchdog reset request
    assign watchdog_reset_req = wd_tick && watchdog_enable_fuse;                         // [RULE13]

    //------------------------------------------------------------
    // gate selection, polarity and toggle
    //------------------------------------------------------------
    logic src_level;
    always_comb begin
        unique case (gate_ctl.source)                                                    // [RULE9]
            TGAC_SRC_PIN:   src_level = gate_input;
            TGAC_SRC_T0OVF: src_level = t0_pulse;
            TGAC_SRC_T2MAT: src_level = t2_pulse;
            TGAC_SRC_WDOG:  src_level = wd_tick && wd_gating;                            // [RULE13]
        endcase
    end
    // polarity is applied before the toggle, so the toggling edge follows it
    wire  pol_level = gate_ctl.polarity ? src_level : !src_level;                        // [RULE7]
    logic pol_prev;
    logic toggle_ff;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pol_prev  <= 1'b0;                                                           // [RULE21]
            toggle_ff <= 1'b0;                                                           // [RULE21]
        end else begin
            pol_prev  <= pol_level;
            if (!gate_ctl.toggle)
                toggle_ff <= 1'b0;                                                       // [RULE18]
            else if (pol_level && !pol_prev)
                toggle_ff <= !toggle_ff;                                                 // [RULE17]
        end
    end
    wire gate_active = gate_ctl.toggle ? toggle_ff : pol_level;                          // [RULE8]
    wire count_en    = counter_on_bit && (!gate_ctl.enable || gate_active);              // [RULE20]

    //------------------------------------------------------------
    // count edge: synchronous or direct
    //------------------------------------------------------------
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic clk_raw_prev;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clk_s1       <= 1'b0;
            clk_s2       <= 1'b0;
            clk_s3       <= 1'b0;
            clk_raw_prev <= 1'b0;
        end else begin
            clk_s1       <= count_clk_in;
            clk_s2       <= clk_s1;
            clk_s3       <= clk_s2;
            clk_raw_prev <= count_clk_in;
        end
    end
    // async path skips the synchroniser; a switch may lose or add one edge
    wire rise_sync  = clk_s2 && !clk_s3;
    wire rise_async = count_clk_in && !clk_raw_prev;                                     // [RULE1]
    wire count_edge = async_select_bit ? rise_async : rise_sync;                         // [RULE3]

    //------------------------------------------------------------
    // 16-bit counter and overflow
    //------------------------------------------------------------
    logic [15:0] count;
    wire         incr       = count_en && count_edge;                                    // [RULE8]
    wire  [15:0] next_count = 16'(count + COUNT_ONE);
    wire         count_full = &count;                                                    // next step rolls over
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count <= COUNT_ZERO;
        end else if (wr_lo) begin
            count[7:0] <= bus.wdata;
        end else if (wr_hi) begin
            count[15:8] <= bus.wdata;
        end else if (incr) begin
            count <= next_count;                                                         // [RULE2]
        end
    end
    // overflow is a one-cycle pulse; wake only in async mode asleep
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            overflow_pulse <= 1'b0;
            wake_request   <= 1'b0;
        end else begin
            overflow_pulse <= incr && count_full;
            wake_request   <= incr && count_full && async_select_bit && sleep_active;    // [RULE2]
        end
    end

    //------------------------------------------------------------
    // read data, registered so bytes are never torn
    //------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = RESET_BYTE;
        unique case (bus.addr)
            ADDR_CTRL:   begin
                rd_mux[CTRL_ON_BIT]    = counter_on_bit;
                rd_mux[CTRL_ASYNC_BIT] = async_select_bit;
            end
            ADDR_GATE:   begin
                rd_mux[GATE_EN_BIT]             = gate_ctl.enable;
                rd_mux[GATE_POL_BIT]            = gate_ctl.polarity;
                rd_mux[GATE_TGL_BIT]            = gate_ctl.toggle;
                rd_mux[GATE_SRC_LSB +: 2]       = gate_ctl.source;
            end
            ADDR_CNT_LO: rd_mux = count[7:0];                                            // [RULE4]
            ADDR_CNT_HI: rd_mux = count[15:8];                                           // [RULE4]
            ADDR_WDOG:   begin
                rd_mux[WD_RATE_LSB +: 3] = prescaler_rate_field;
                rd_mux[WD_ASSIGN_BIT]    = prescaler_assign_bit;
                rd_mux[WD_FUSE_BIT]      = watchdog_enable_fuse;
            end
            ADDR_STATUS: begin
                rd_mux[ST_WDOSC_BIT] = watchdog_osc_on;
                rd_mux[ST_GATE_BIT]  = gate_active;
                rd_mux[ST_TGL_BIT]   = toggle_ff;
                rd_mux[ST_ASYNC_BIT] = async_select_bit;
            end
            default:     rd_mux = RESET_BYTE;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (reset)
            bus_rdata <= RESET_BYTE;
        else if (bus.rd)
            bus_rdata <= rd_mux;
        else
            bus_rdata <= RESET_BYTE;
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_count_step;
        incr && !wr_lo && !wr_hi;
    endsequence

    a_off_holds: assert property (!counter_on_bit && !wr_lo && !wr_hi |=> $stable(count)) // [RULE20]
        else $error("counter moved while off");
    a_count_step: assert property (s_count_step |=> count == $past(next_count))        // [RULE8]
        else $error("counter did not step by one");
    a_gate_hold: assert property (counter_on_bit && gate_ctl.enable && !gate_active && !wr_lo && !wr_hi
        |=> $stable(count))                                                              // [RULE7]
        else $error("counter moved with gate inactive");
    a_free_run: assert property (counter_on_bit && !gate_ctl.enable && count_edge && !wr_lo && !wr_hi
        |=> count == 16'($past(count) + COUNT_ONE))                                      // [RULE20]
        else $error("free run missed an edge");
    a_toggle_clear: assert property (!gate_ctl.toggle |=> !toggle_ff)                  // [RULE18]
        else $error("toggle flop not held clear");
    a_toggle_flip: assert property (gate_ctl.toggle && pol_level && !pol_prev && !wr_gate
        |=> toggle_ff != $past(toggle_ff))                                               // [RULE17]
        else $error("toggle flop missed an edge");
    a_wdog_osc: assert property (wd_gating |-> watchdog_osc_on)                        // [RULE12]
        else $error("watchdog oscillator off while gating");
    a_wdog_noreset: assert property (!watchdog_enable_fuse |-> !watchdog_reset_req)     // [RULE13]
        else $error("watchdog reset without fuse");
    a_t0_pulse: assert property (gate_ctl.source == TGAC_SRC_T0OVF && t0_prev == T0_TOP
        && eight_bit_timer_count == RESET_BYTE |-> src_level)                            // [RULE10]
        else $error("eight-bit overflow pulse missing");
    a_read_stable: assert property (bus.rd && hit(bus.addr, ADDR_CNT_LO) |=> bus_rdata == $past(count[7:0])) // [RULE4]
        else $error("low byte read torn");

endmodule // tgac_counter

/* File: hdl/tgac_pkg.sv */
// package of constants and types for the gated asynchronous counter
package tgac_pkg;

    //------------------------------------------------------------
    // register map
    //------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL    = 4'h0;  // counter_control_reg
    localparam logic [3:0] ADDR_GATE    = 4'h1;  // gate_control_reg
    localparam logic [3:0] ADDR_CNT_LO  = 4'h2;  // count_low_byte
    localparam logic [3:0] ADDR_CNT_HI  = 4'h3;  // count_high_byte
    localparam logic [3:0] ADDR_WDOG    = 4'h4;  // watchdog prescaler
    localparam logic [3:0] ADDR_STATUS  = 4'h5;  // status

    // counter_control_reg fields
    localparam int CTRL_ON_BIT    = 0;
    localparam int CTRL_ASYNC_BIT = 2;
    // gate_control_reg fields
    localparam int GATE_SRC_LSB   = 0;
    localparam int GATE_TGL_BIT   = 5;
    localparam int GATE_POL_BIT   = 6;
    localparam int GATE_EN_BIT    = 7;
    // watchdog register fields
    localparam int WD_RATE_LSB    = 0;
    localparam int WD_ASSIGN_BIT  = 3;
    localparam int WD_FUSE_BIT    = 4;
    // status fields
    localparam int ST_WDOSC_BIT   = 0;
    localparam int ST_GATE_BIT    = 1;
    localparam int ST_TGL_BIT     = 2;
    localparam int ST_ASYNC_BIT   = 3;

    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [7:0]  T0_TOP       = 8'hFF;
    localparam logic [7:0]  T2_ZERO      = 8'h00;
    localparam logic [15:0] COUNT_ZERO   = 16'h0000;
    localparam logic [15:0] COUNT_ONE    = 16'h0001;
    localparam logic [15:0] WD_BASE_TOP  = 16'h00FF; // last count of the base watchdog period of 256 cycles
    localparam logic [7:0]  WD_PRE_ONE   = 8'h01;

    //------------------------------------------------------------
    // gate source encoding
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        TGAC_SRC_PIN   = 2'b00,
        TGAC_SRC_T0OVF = 2'b01,
        TGAC_SRC_T2MAT = 2'b10,
        TGAC_SRC_WDOG  = 2'b11
    } tgac_src_t;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tgac_bus_t;

    // gate control fields
    typedef struct packed {
        logic      enable;
        logic      polarity;
        logic      toggle;
        tgac_src_t source;
    } tgac_gate_t;

endpackage : tgac_pkg

/* File: sim/tgac_far_end.sv */
// far-side model: external count clock source and gate pin driver
`timescale 1ns/1ps

module tgac_far_end
    import tgac_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // burst request from the bench
    input  wire logic       go,
    input  wire logic [7:0] pulses,
    input  wire logic       gate_req,
    // pins toward the counter, and busy back to the bench
    output logic            count_clk_in,
    output logic            gate_input,
    output logic            busy
);
    logic [7:0] left;
    logic [1:0] phase;

    //------------------------------------------------------------
    // burst generator
    //------------------------------------------------------------
    // each level is held three cycles so sync and async modes both see it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            left         <= 8'h00;
            phase        <= 2'b00;
            count_clk_in <= 1'b0;
        end else if (go) begin
            left  <= pulses;
            phase <= 2'b00;
        end else if (left != 8'h00) begin
            phase <= phase + 2'b01;
            if (phase == 2'b10) begin
                phase        <= 2'b00;
                count_clk_in <= ~count_clk_in;
                if (count_clk_in) begin
                    left <= left - 8'h01;
                end
            end
        end
    end

    // clock stands low between bursts; the gate pin is driven at all times
    assign busy       = (left != 8'h00);
    assign gate_input = gate_req;
endmodule // tgac_far_end

/* File: sim/tgac_counter_bench.sv */
// self-checking testbench for the gated asynchronous counter
`timescale 1ns/1ps

module tgac_counter_bench
    import tgac_pkg::*;
;
    //------------------------------------------------------------
    // signals
    //------------------------------------------------------------
    logic       ref_clk, reset, count_clk_in, gate_input, wd_clr, sleep_active;
    tgac_bus_t  bus;
    logic [7:0] bus_rdata, eight_cnt, period_cnt, pulses;
    logic       overflow_pulse, wake_request, watchdog_osc_on, watchdog_reset_req;
    logic       go, busy, gate_req;
    logic [7:0] d;
    logic [15:0] c;
    int         bad_count, comparisons, ovf_n, wake_n, wdr_n, b0, b1, b2;

    tgac_counter i_tgac_counter (.ref_clk(ref_clk), .reset(reset), .bus_addr(bus.addr), .bus_wdata(bus.wdata),
        .bus_wr(bus.wr), .bus_rd(bus.rd), .bus_rdata(bus_rdata), .count_clk_in(count_clk_in),
        .gate_input(gate_input), .eight_bit_timer_count(eight_cnt), .period_timer_count(period_cnt),
        .watchdog_clear_instr(wd_clr), .sleep_active(sleep_active), .overflow_pulse(overflow_pulse),
        .wake_request(wake_request), .watchdog_osc_on(watchdog_osc_on), .watchdog_reset_req(watchdog_reset_req));
    tgac_far_end i_tgac_far_end (.ref_clk(ref_clk), .reset(reset), .go(go), .pulses(pulses), .gate_req(gate_req),
        .count_clk_in(count_clk_in), .gate_input(gate_input), .busy(busy));

    //------------------------------------------------------------
    // clock, event counters, watchdog
    //------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (overflow_pulse === 1'b1) ovf_n++;
        if (wake_request === 1'b1) wake_n++;
        if (watchdog_reset_req === 1'b1) wdr_n++;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end

    //------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus.addr <= a; bus.wdata <= v; bus.wr <= 1'b1;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        bus.addr <= a; bus.rd <= 1'b1;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 v = bus_rdata;
    endtask
    task automatic cnt_rd(output logic [15:0] v);
        logic [7:0] lo, hi;
        rd(ADDR_CNT_LO, lo);
        rd(ADDR_CNT_HI, hi);
        v = {hi, lo};
    endtask
    task automatic set_count(input logic [15:0] v);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CNT_LO, v[7:0]);
        wr(ADDR_CNT_HI, v[15:8]);
    endtask
    task automatic pulse(input logic [7:0] n);
        @(posedge ref_clk);
        go <= 1'b1; pulses <= n;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 3000 && busy; i++) @(posedge ref_clk);
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic edge_src(input int s);
        @(posedge ref_clk);
        if (s == 0) gate_req <= 1'b0; else if (s == 1) eight_cnt <= 8'hFF; else period_cnt <= 8'h05;
        repeat (4) @(posedge ref_clk);
        if (s == 0) gate_req <= 1'b1; else if (s == 1) eight_cnt <= 8'h00; else period_cnt <= 8'h00;
        repeat (6) @(posedge ref_clk);
    endtask

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic t_reset();
        for (int a = 0; a < 6; a++) begin
            rd(4'(a), d);
            check({8'h00, d}, (a == 5) ? 16'h0002 : 16'h0000);
        end
        rd(4'hF, d);
        check({8'h00, d}, 16'h0000);
        check({15'h0000, watchdog_osc_on}, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_free();
        set_count(16'h0005);
        wr(ADDR_GATE, 8'h00);
        wr(ADDR_CTRL, 8'h05);
        pulse(8'h03);
        cnt_rd(c);
        check(c, 16'h0008);
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_GATE, 8'h80);
        pulse(8'h02);
        cnt_rd(c);
        check(c, 16'h0008);
        wr(ADDR_GATE, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        pulse(8'h02);
        cnt_rd(c);
        check(c, 16'h000A);
        $display("test free running done");
    endtask
    task automatic t_pin_gate();
        for (int p = 0; p < 2; p++) begin
            set_count(16'h0000);
            wr(ADDR_GATE, {1'b1, 1'(p), 6'h00});
            wr(ADDR_CTRL, 8'h05);
            @(posedge ref_clk) gate_req <= ~1'(p);
            pulse(8'h02);
            cnt_rd(c);
            check(c, 16'h0000);
            @(posedge ref_clk) gate_req <= 1'(p);
            pulse(8'h03);
            cnt_rd(c);
            check(c, 16'h0003);
        end
        $display("test pin gate done");
    endtask
    task automatic t_overflow();
        set_count(16'hFFFE);
        wr(ADDR_GATE, 8'h00);
        wr(ADDR_CTRL, 8'h05);
        b0 = ovf_n; b1 = wake_n;
        @(posedge ref_clk) sleep_active <= 1'b1;
        pulse(8'h02);
        @(posedge ref_clk) sleep_active <= 1'b0;
        cnt_rd(c);
        check(c, 16'h0000);
        check(16'(ovf_n - b0), 16'h0001);
        check(16'(wake_n - b1), 16'h0001);
        $display("test overflow done");
    endtask
    task automatic t_toggle();
        wr(ADDR_CTRL, 8'h05);
        @(posedge ref_clk) gate_req <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_GATE, {6'h30, 2'(s)});
            rd(ADDR_STATUS, d);
            check({15'h0000, d[ST_TGL_BIT]}, 16'h0000);
            wr(ADDR_GATE, {6'h38, 2'(s)});
            edge_src(s);
            rd(ADDR_STATUS, d);
            check({15'h0000, d[ST_TGL_BIT]}, 16'h0001);
            edge_src(s);
            rd(ADDR_STATUS, d);
            check({15'h0000, d[ST_TGL_BIT]}, 16'h0000);
            edge_src(s);
            rd(ADDR_STATUS, d);
            check({15'h0000, d[ST_TGL_BIT]}, 16'h0001);
        end
        $display("test toggle sources done");
    endtask
    task automatic t_wdog();
        b2 = wdr_n;
        wr(ADDR_CTRL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_GATE, 8'hC3);
            wr(ADDR_WDOG, (k == 0) ? 8'h00 : 8'h09);
            check({15'h0000, watchdog_osc_on}, 16'h0001);
            @(posedge ref_clk) wd_clr <= 1'b1;
            @(posedge ref_clk) wd_clr <= 1'b0;
            wr(ADDR_GATE, 8'hE3);
            repeat (140) @(posedge ref_clk);
            rd(ADDR_STATUS, d);
            check({15'h0000, d[ST_TGL_BIT]}, 16'h0000);
            repeat ((k == 0) ? 150 : 450) @(posedge ref_clk);
            rd(ADDR_STATUS, d);
            check({15'h0000, d[ST_TGL_BIT]}, 16'h0001);
        end
        check(16'(wdr_n - b2), 16'h0000);
        wr(ADDR_WDOG, 8'h10);
        @(posedge ref_clk) wd_clr <= 1'b1;
        @(posedge ref_clk) wd_clr <= 1'b0;
        b2 = wdr_n;
        repeat (300) @(posedge ref_clk);
        check(16'(wdr_n - b2), 16'h0001);
        @(posedge ref_clk) reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(ADDR_STATUS, d);
        check({8'h00, d}, 16'h0000);
        check({15'h0000, watchdog_osc_on}, 16'h0000);
        $display("test watchdog gate done");
    endtask

    //------------------------------------------------------------
    // verdict and main sequence
    //------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1; bus = '0; gate_req = 1'b0; go = 1'b0; pulses = 8'h00;
        eight_cnt = 8'h00; period_cnt = 8'h00; wd_clr = 1'b0; sleep_active = 1'b0;
        bad_count = 0; comparisons = 0; ovf_n = 0; wake_n = 0; wdr_n = 0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_free();
        t_pin_gate();
        t_overflow();
        t_toggle();
        t_wdog();
        conclude();
    end
endmodule // tgac_counter_bench
